// ### rtl/bit_branch_pkg.sv
`default_nettype none
package bit_branch_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_FLAGS   = 8'h04;
  localparam logic [7:0] OFF_OPERAND = 8'h08;
  localparam logic [7:0] OFF_BITREG  = 8'h0C;
  localparam logic [7:0] OFF_MEMADDR = 8'h10;
  localparam logic [7:0] OFF_PC      = 8'h14;
  localparam logic [7:0] OFF_TARGET  = 8'h18;
  localparam logic [7:0] OFF_SP      = 8'h1C;
  localparam logic [7:0] OFF_STATUS  = 8'h20;

  // Control word fields
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_BREG_BIT = 5;
  localparam int CTRL_MEM_BIT  = 6;
  localparam int CTRL_IMM_LSB  = 8;
  localparam int CTRL_COND_LSB = 12;

  // Flag positions in the flags register
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;

  // Status positions
  localparam int STAT_BUSY  = 0;
  localparam int STAT_TAKEN = 1;

  // Reset values
  localparam logic [3:0]  FLAGS_RST = 4'h0;
  localparam logic [31:0] PC_RST    = 32'h0000_0000;
  localparam logic [31:0] SP_RST    = 32'h0000_0000;

  // Stack slot size in bytes
  localparam logic [31:0] STACK_STEP = 32'h0000_0004;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    carry_or_bit,
    carry_or_inverted_bit,
    carry_xor_bit,
    carry_xor_inverted_bit,
    load_bit_to_carry,
    load_inverted_bit_to_carry,
    store_carry_to_bit,
    store_inverted_carry_to_bit,
    cond_jump,
    goto_target,
    relative_call,
    absolute_call,
    sub_return
  } op_e;

  typedef enum logic [3:0] {
    always_taken_jump,
    never_taken_jump,
    jump_if_higher,
    jump_if_lower_or_same,
    jump_if_carry_clear,
    jump_if_carry_set,
    jump_if_unequal,
    jump_if_equal,
    jump_if_no_overflow,
    jump_if_overflow,
    jump_if_positive,
    jump_if_negative,
    jump_if_signed_ge,
    jump_if_signed_lt,
    jump_if_signed_gt,
    jump_if_signed_le
  } cond_e;

endpackage
`default_nettype wire

// ### rtl/branch_cond_eval.sv
`timescale 1ns/1ps
`default_nettype none
module branch_cond_eval (
  // Condition code
  input  wire logic [3:0] cond,
  // Flags
  input  wire logic       c,
  input  wire logic       v,
  input  wire logic       z,
  input  wire logic       n,
  // Result
  output logic            taken
);
  always_comb begin
    case (cond)
      bit_branch_pkg::always_taken_jump:     taken = 1'b1;
      bit_branch_pkg::never_taken_jump:      taken = 1'b0;
      bit_branch_pkg::jump_if_higher:        taken = ~(c | z);
      bit_branch_pkg::jump_if_lower_or_same: taken = c | z;
      bit_branch_pkg::jump_if_carry_clear:   taken = ~c;
      bit_branch_pkg::jump_if_carry_set:     taken = c;
      bit_branch_pkg::jump_if_unequal:       taken = ~z;
      bit_branch_pkg::jump_if_equal:         taken = z;
      bit_branch_pkg::jump_if_no_overflow:   taken = ~v;
      bit_branch_pkg::jump_if_overflow:      taken = v;
      bit_branch_pkg::jump_if_positive:      taken = ~n;
      bit_branch_pkg::jump_if_negative:      taken = n;
      bit_branch_pkg::jump_if_signed_ge:     taken = ~(n ^ v);
      bit_branch_pkg::jump_if_signed_lt:     taken = n ^ v;
      bit_branch_pkg::jump_if_signed_gt:     taken = ~(z | (n ^ v));
      bit_branch_pkg::jump_if_signed_le:     taken = z | (n ^ v);
      default:                               taken = 1'b0;
    endcase
  end
endmodule // branch_cond_eval
`default_nettype wire

// ### rtl/bit_carry_branch.sv
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bit_carry_branch #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Operand memory
  output logic                   mem_req,
  output logic                   mem_we,
  output logic                   mem_word,
  output logic [31:0]            mem_addr,
  output logic [31:0]            mem_wdata,
  input  wire logic [31:0]       mem_rdata,
  input  wire logic              mem_ack
);

  typedef enum logic [2:0] {
    s_idle,
    s_exec,
    s_mem_rd,
    s_mem_wr,
    s_pop
  } st_e;

  typedef struct packed {
    st_e         st;
    logic        aw_hold;
    logic [7:0]  awaddr;
    logic        w_hold;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [15:0] ctrl;
    logic [3:0]  flags;
    logic [7:0]  operand;
    logic [7:0]  bitreg;
    logic [31:0] memaddr;
    logic [31:0] pc;
    logic [31:0] target;
    logic [31:0] sp;
    logic        taken;
    logic        mreq;
    logic        mwe;
    logic        mword;
    logic [31:0] maddr;
    logic [31:0] mwdata;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  logic       cond_taken;

  // Byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Carry result of the combine and load operations
  function automatic logic carry_of(input logic [3:0] op,
                                    input logic       c,
                                    input logic       b);
    logic r;
    r = c;
    case (op)
      bit_branch_pkg::carry_or_bit:               r = c | b;
      bit_branch_pkg::carry_or_inverted_bit:      r = c | ~b;
      bit_branch_pkg::carry_xor_bit:              r = c ^ b;
      bit_branch_pkg::carry_xor_inverted_bit:     r = c ^ ~b;
      bit_branch_pkg::load_bit_to_carry:          r = b;
      bit_branch_pkg::load_inverted_bit_to_carry: r = ~b;
      default:                                    r = c;
    endcase
    return r;
  endfunction

  // Byte with one bit replaced by the carry or its inverse
  function automatic logic [7:0] store_of(input logic [3:0] op,
                                          input logic [7:0] byte_in,
                                          input logic [2:0] idx,
                                          input logic       c);
    logic [7:0] r;
    r = byte_in;
    if (op == bit_branch_pkg::store_inverted_carry_to_bit) begin
      r[idx] = ~c;
    end else begin
      r[idx] = c;
    end
    return r;
  endfunction

  function automatic logic is_store(input logic [3:0] op);
    return (op == bit_branch_pkg::store_carry_to_bit) ||
           (op == bit_branch_pkg::store_inverted_carry_to_bit);
  endfunction

  branch_cond_eval branch_cond_eval_i (
    .cond  (s_r.ctrl[bit_branch_pkg::CTRL_COND_LSB +: 4]),
    .c     (s_r.flags[bit_branch_pkg::FLAG_C]),
    .v     (s_r.flags[bit_branch_pkg::FLAG_V]),
    .z     (s_r.flags[bit_branch_pkg::FLAG_Z]),
    .n     (s_r.flags[bit_branch_pkg::FLAG_N]),
    .taken (cond_taken)
  );

  assign s_axi_awready = ~s_r.aw_hold & ~s_r.bvalid;
  assign s_axi_wready  = ~s_r.w_hold & ~s_r.bvalid;
  assign s_axi_arready = ~s_r.rvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rdata   = s_r.rdata;
  assign mem_req       = s_r.mreq;
  assign mem_we        = s_r.mwe;
  assign mem_word      = s_r.mword;
  assign mem_addr      = s_r.maddr;
  assign mem_wdata     = s_r.mwdata;

  always_comb begin
    logic [3:0]  op;
    logic [2:0]  bitno;
    logic        inv;
    logic        busy;
    logic [7:0]  rdaddr;
    logic [7:0]  byte_v;
    logic [31:0] rv;
    logic        hit;
    op     = 4'h0;
    bitno  = 3'h0;
    inv    = 1'b0;
    busy   = 1'b0;
    rdaddr = 8'h00;
    byte_v = 8'h00;
    rv     = 32'h0000_0000;
    hit    = 1'b0;
    s_nxt  = s_r;

    op   = s_r.ctrl[bit_branch_pkg::CTRL_OP_LSB +: 4];
    inv  = (op == bit_branch_pkg::carry_or_inverted_bit) ||
           (op == bit_branch_pkg::carry_xor_inverted_bit) ||
           (op == bit_branch_pkg::load_inverted_bit_to_carry) ||
           (op == bit_branch_pkg::store_inverted_carry_to_bit);
    busy = (s_r.st != s_idle);
    // Inverted forms ignore the register-select bit
    if (inv || !s_r.ctrl[bit_branch_pkg::CTRL_BREG_BIT]) begin
      bitno = s_r.ctrl[bit_branch_pkg::CTRL_IMM_LSB +: 3];
    end else begin
      bitno = s_r.bitreg[2:0];
    end

    // Write channels, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_hold = 1'b1;
      s_nxt.awaddr  = 8'(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_hold = 1'b1;
      s_nxt.wdata  = s_axi_wdata;
      s_nxt.wstrb  = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_hold && s_r.w_hold && !s_r.bvalid) begin
      s_nxt.aw_hold = 1'b0;
      s_nxt.w_hold  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = bit_branch_pkg::RESP_OKAY;
      // Writes during an operation are dropped so state stays coherent
      case (s_r.awaddr)
        bit_branch_pkg::OFF_CTRL: begin
          if (!busy) begin
            s_nxt.ctrl = 16'(merge({16'h0000, s_r.ctrl}, s_r.wdata,
                                   s_r.wstrb));
            s_nxt.st   = s_exec;
          end
        end
        bit_branch_pkg::OFF_FLAGS: begin
          if (!busy) begin
            s_nxt.flags = 4'(merge({28'h0, s_r.flags}, s_r.wdata, s_r.wstrb));
          end
        end
        bit_branch_pkg::OFF_OPERAND: begin
          if (!busy) begin
            s_nxt.operand = 8'(merge({24'h0, s_r.operand}, s_r.wdata,
                                     s_r.wstrb));
          end
        end
        bit_branch_pkg::OFF_BITREG: begin
          if (!busy) begin
            s_nxt.bitreg = 8'(merge({24'h0, s_r.bitreg}, s_r.wdata,
                                    s_r.wstrb));
          end
        end
        bit_branch_pkg::OFF_MEMADDR: begin
          if (!busy) begin
            s_nxt.memaddr = merge(s_r.memaddr, s_r.wdata, s_r.wstrb);
          end
        end
        bit_branch_pkg::OFF_PC: begin
          if (!busy) begin
            s_nxt.pc = merge(s_r.pc, s_r.wdata, s_r.wstrb);
          end
        end
        bit_branch_pkg::OFF_TARGET: begin
          if (!busy) begin
            s_nxt.target = merge(s_r.target, s_r.wdata, s_r.wstrb);
          end
        end
        bit_branch_pkg::OFF_SP: begin
          if (!busy) begin
            s_nxt.sp = merge(s_r.sp, s_r.wdata, s_r.wstrb);
          end
        end
        bit_branch_pkg::OFF_STATUS: begin
          s_nxt.bresp = bit_branch_pkg::RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = bit_branch_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Read channel
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rdaddr = 8'(s_axi_araddr);
      hit    = 1'b1;
      case (rdaddr)
        bit_branch_pkg::OFF_CTRL:    rv = {16'h0000, s_r.ctrl};
        bit_branch_pkg::OFF_FLAGS:   rv = {28'h0, s_r.flags};
        bit_branch_pkg::OFF_OPERAND: rv = {24'h0, s_r.operand};
        bit_branch_pkg::OFF_BITREG:  rv = {24'h0, s_r.bitreg};
        bit_branch_pkg::OFF_MEMADDR: rv = s_r.memaddr;
        bit_branch_pkg::OFF_PC:      rv = s_r.pc;
        bit_branch_pkg::OFF_TARGET:  rv = s_r.target;
        bit_branch_pkg::OFF_SP:      rv = s_r.sp;
        bit_branch_pkg::OFF_STATUS:  rv = {30'h0, s_r.taken, busy};
        default:                     hit = 1'b0;
      endcase
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rv;
      s_nxt.rresp  = hit ? bit_branch_pkg::RESP_OKAY :
                           bit_branch_pkg::RESP_SLVERR;
    end

    // Execution sequencer; flags other than carry are never written here
    case (s_r.st)
      s_idle: begin
        s_nxt.mreq = 1'b0;
      end
      s_exec: begin
        s_nxt.taken = 1'b0;
        if (op <= bit_branch_pkg::store_inverted_carry_to_bit) begin
          if (s_r.ctrl[bit_branch_pkg::CTRL_MEM_BIT]) begin
            s_nxt.mreq  = 1'b1;
            s_nxt.mwe   = 1'b0;
            s_nxt.mword = 1'b0;
            s_nxt.maddr = s_r.memaddr;
            s_nxt.st    = s_mem_rd;
          end else if (is_store(op)) begin
            s_nxt.operand = store_of(op, s_r.operand, bitno,
                                     s_r.flags[bit_branch_pkg::FLAG_C]);
            s_nxt.st      = s_idle;
          end else begin
            s_nxt.flags[bit_branch_pkg::FLAG_C] =
              carry_of(op, s_r.flags[bit_branch_pkg::FLAG_C],
                       s_r.operand[bitno]);
            s_nxt.st = s_idle;
          end
        end else begin
          s_nxt.st = s_idle;
          case (op)
            bit_branch_pkg::cond_jump: begin
              s_nxt.taken = cond_taken;
              if (cond_taken) begin
                s_nxt.pc = s_r.target;
              end
            end
            bit_branch_pkg::goto_target: begin
              s_nxt.taken = 1'b1;
              s_nxt.pc    = s_r.target;
            end
            bit_branch_pkg::relative_call,
            bit_branch_pkg::absolute_call: begin
              // Push address of the next instruction
              s_nxt.taken  = 1'b1;
              s_nxt.sp     = s_r.sp - bit_branch_pkg::STACK_STEP;
              s_nxt.mreq   = 1'b1;
              s_nxt.mwe    = 1'b1;
              s_nxt.mword  = 1'b1;
              s_nxt.maddr  = s_r.sp - bit_branch_pkg::STACK_STEP;
              s_nxt.mwdata = s_r.pc;
              if (op == bit_branch_pkg::relative_call) begin
                s_nxt.pc = s_r.pc + s_r.target;
              end else begin
                s_nxt.pc = s_r.target;
              end
              s_nxt.st = s_mem_wr;
            end
            bit_branch_pkg::sub_return: begin
              s_nxt.taken = 1'b1;
              s_nxt.mreq  = 1'b1;
              s_nxt.mwe   = 1'b0;
              s_nxt.mword = 1'b1;
              s_nxt.maddr = s_r.sp;
              s_nxt.st    = s_pop;
            end
            default: begin
              s_nxt.taken = 1'b0;
            end
          endcase
        end
      end
      s_mem_rd: begin
        if (mem_ack) begin
          byte_v = mem_rdata[7:0];
          if (is_store(op)) begin
            s_nxt.mwe    = 1'b1;
            s_nxt.mwdata = {24'h0, store_of(op, byte_v, bitno,
                                   s_r.flags[bit_branch_pkg::FLAG_C])};
            s_nxt.st     = s_mem_wr;
          end else begin
            s_nxt.mreq = 1'b0;
            s_nxt.flags[bit_branch_pkg::FLAG_C] =
              carry_of(op, s_r.flags[bit_branch_pkg::FLAG_C],
                       byte_v[bitno]);
            s_nxt.st = s_idle;
          end
        end
      end
      s_mem_wr: begin
        if (mem_ack) begin
          s_nxt.mreq = 1'b0;
          s_nxt.mwe  = 1'b0;
          s_nxt.st   = s_idle;
        end
      end
      s_pop: begin
        if (mem_ack) begin
          s_nxt.mreq = 1'b0;
          s_nxt.pc   = mem_rdata;
          s_nxt.sp   = s_r.sp + bit_branch_pkg::STACK_STEP;
          s_nxt.st   = s_idle;
        end
      end
      default: begin
        s_nxt.st = s_idle;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r       <= '0;
      s_r.st    <= s_idle;
      s_r.flags <= bit_branch_pkg::FLAGS_RST;
      s_r.pc    <= bit_branch_pkg::PC_RST;
      s_r.sp    <= bit_branch_pkg::SP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // bit_carry_branch
`default_nettype wire

// ### tb/bit_carry_branch_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module bit_carry_branch_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Operand memory
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_word,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_ack
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while rvalid");
  a_wr_blocked: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("ready while bvalid");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("bvalid stuck");
  a_mem_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata)) else $error("mem req moved");
  a_rmw_addr: assert property (
    mem_req && mem_ack && !mem_we |=> !mem_req
    || (mem_we && $stable(mem_addr))) else $error("write back elsewhere");
  a_write_ends: assert property (
    mem_req && mem_ack && mem_we |=> !mem_req) else $error("req after write");
  a_reset_idle: assert property ($rose(aresetn)
    |-> !s_axi_bvalid && !s_axi_rvalid && !mem_req) else $error("not idle");
  cover property (mem_req && mem_ack && mem_we && !mem_word);
  cover property (mem_req && mem_ack && mem_word);
  cover property (s_axi_arvalid && s_axi_arready);
endmodule // bit_carry_branch_checker

bind bit_carry_branch bit_carry_branch_checker bit_carry_branch_checker_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack));
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdm = 32'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, ack = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, mreq, mwe, mword;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, maddr, mwdata;
  int          err_count = 0, num_checks = 0;

  bit_carry_branch bit_carry_branch_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mem_req(mreq),
    .mem_we(mwe), .mem_word(mword), .mem_addr(maddr), .mem_wdata(mwdata),
    .mem_rdata(rdm), .mem_ack(ack));

  always #25 aclk = ~aclk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk({30'h0, bresp}, 32'h0);
  endtask

  // Ready held back a cycle so the read answer has to stand
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h1;
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, bit_branch_pkg::RESP_OKAY});
  endtask

  task automatic idle;
    logic [31:0] d;
    logic [1:0]  r;
    do rd(bit_branch_pkg::OFF_STATUS, d, r);
    while (d[bit_branch_pkg::STAT_BUSY] !== 1'h0);
  endtask

  task automatic go(input logic [31:0] c);
    wr(bit_branch_pkg::OFF_CTRL, c);
    idle;
  endtask

  task automatic serve(input logic we, input logic wd, input logic [31:0] a,
                       input logic [31:0] w, input logic [31:0] rv);
    do @(posedge aclk);
    while (!(mreq === 1'h1 && mwe === we));
    chk({31'h0, mword}, {31'h0, wd});
    chk(maddr, a);
    if (we) chk(mwdata, w);
    rdm <= rv;
    ack <= 1'h1;
    @(posedge aclk);
    ack <= 1'h0;
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rc(bit_branch_pkg::OFF_FLAGS, 32'h0);
    rc(bit_branch_pkg::OFF_PC, 32'h0);
    rc(bit_branch_pkg::OFF_SP, 32'h0);
    rd(8'h24, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, bit_branch_pkg::RESP_SLVERR});
    $display("test reset done");
  endtask

  task automatic t_bits;
    logic [7:0] v;
    logic [2:0] i, m;
    logic       c, b, nc, inv, sel;
    for (int op = 0; op < 8; op++) begin
      for (int k = 0; k < 2; k++) begin
        v = 8'hA5 ^ 8'(op * 17);
        i = 3'(op + k * 3);
        c = 1'(k);
        b = v[i];
        inv = 1'(op);
        sel = inv | c;
        m = (inv | !c) ? i : ~i;
        wr(bit_branch_pkg::OFF_FLAGS, {28'h0, 3'h5, c});
        wr(bit_branch_pkg::OFF_OPERAND, {24'h0, v});
        wr(bit_branch_pkg::OFF_BITREG, {29'h0, inv ? ~i : i});
        go(32'(op) | {26'h0, sel, 5'h00} | {21'h0, m, 8'h00});
        case (op)
          0: nc = c | b;
          1: nc = c | !b;
          2: nc = c ^ b;
          3: nc = c ^ !b;
          4: nc = b;
          5: nc = !b;
          default: nc = c;
        endcase
        if (op == 6) v[i] = c;
        if (op == 7) v[i] = !c;
        rc(bit_branch_pkg::OFF_FLAGS, {28'h0, 3'h5, nc});
        rc(bit_branch_pkg::OFF_OPERAND, {24'h0, v});
      end
    end
    $display("test bits done");
  endtask

  task automatic t_branch;
    logic        c, v, z, n;
    logic [15:0] e;
    for (int cd = 0; cd < 16; cd++) begin
      for (int f = 0; f < 16; f++) begin
        {n, z, v, c} = 4'(f);
        e = {z | (n ^ v), !(z | (n ^ v)), n ^ v, !(n ^ v), n, !n, v, !v,
             z, !z, c, !c, c | z, !(c | z), 1'h0, 1'h1};
        wr(bit_branch_pkg::OFF_FLAGS, 32'(f));
        wr(bit_branch_pkg::OFF_PC, 32'h100);
        wr(bit_branch_pkg::OFF_TARGET, 32'h200);
        go(32'h8 | 32'(cd * 4096));
        rc(bit_branch_pkg::OFF_PC, e[cd] ? 32'h200 : 32'h100);
        rc(bit_branch_pkg::OFF_STATUS, {30'h0, e[cd], 1'h0});
        rc(bit_branch_pkg::OFF_FLAGS, 32'(f));
      end
    end
    $display("test branch done");
  endtask

  task automatic t_calls;
    wr(bit_branch_pkg::OFF_SP, 32'h40);
    wr(bit_branch_pkg::OFF_PC, 32'h100);
    wr(bit_branch_pkg::OFF_TARGET, 32'h300);
    wr(bit_branch_pkg::OFF_CTRL, 32'hB);
    serve(1'h1, 1'h1, 32'h3C, 32'h100, 32'h0);
    idle;
    rc(bit_branch_pkg::OFF_PC, 32'h300);
    rc(bit_branch_pkg::OFF_SP, 32'h3C);
    wr(bit_branch_pkg::OFF_TARGET, 32'h20);
    wr(bit_branch_pkg::OFF_CTRL, 32'hA);
    serve(1'h1, 1'h1, 32'h38, 32'h300, 32'h0);
    idle;
    rc(bit_branch_pkg::OFF_PC, 32'h320);
    wr(bit_branch_pkg::OFF_CTRL, 32'hC);
    serve(1'h0, 1'h1, 32'h38, 32'h0, 32'h300);
    idle;
    rc(bit_branch_pkg::OFF_PC, 32'h300);
    rc(bit_branch_pkg::OFF_SP, 32'h3C);
    wr(bit_branch_pkg::OFF_TARGET, 32'h555);
    go(32'h9);
    rc(bit_branch_pkg::OFF_PC, 32'h555);
    rc(bit_branch_pkg::OFF_FLAGS, 32'hF);
    $display("test calls done");
  endtask

  task automatic t_mem;
    wr(bit_branch_pkg::OFF_FLAGS, 32'h1);
    wr(bit_branch_pkg::OFF_MEMADDR, 32'h80);
    wr(bit_branch_pkg::OFF_CTRL, 32'h246);
    // Flag write lands while busy and must be dropped
    wr(bit_branch_pkg::OFF_FLAGS, 32'h0);
    serve(1'h0, 1'h0, 32'h80, 32'h0, 32'hF0);
    serve(1'h1, 1'h0, 32'h80, 32'hF4, 32'h0);
    idle;
    rc(bit_branch_pkg::OFF_FLAGS, 32'h1);
    wr(bit_branch_pkg::OFF_CTRL, 32'h347);
    serve(1'h0, 1'h0, 32'h80, 32'h0, 32'hFF);
    serve(1'h1, 1'h0, 32'h80, 32'hF7, 32'h0);
    idle;
    wr(bit_branch_pkg::OFF_CTRL, 32'h745);
    serve(1'h0, 1'h0, 32'h80, 32'h0, 32'h80);
    idle;
    rc(bit_branch_pkg::OFF_FLAGS, 32'h0);
    $display("test mem done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_bits;
    t_branch;
    t_calls;
    t_mem;
    stop_test;
  end

  // Run needs about 9k cycles; generous margin
  initial begin
    repeat (80000) @(posedge aclk);
    err_count++;
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
